// file: logic/spi_flash_status_control.sv
// serial flash status byte handling: busy, reset enable, lock, write enable
`include "flash_status_map.svh"
module spi_flash_status_control
  import flash_status_pkg::*;
#(
  parameter logic [3:0] GLOBAL_PROTECT_CODE   = `GLOBAL_PROTECT,
  parameter logic [3:0] GLOBAL_UNPROTECT_CODE = `GLOBAL_UNPROTECT
) (
  // system clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // serial link, sck domain
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so,
  output logic      so_oe_n,
  // write protect pin
  input  wire logic wp_n,
  // internal engine status and control
  input  wire logic busy_in,
  input  wire logic reset_req,
  output logic      soft_reset,
  output logic      global_protect,
  output logic      global_unprotect,
  output logic      write_enable_latch,
  output logic      protect_regs_lock,
  output logic      reset_cmd_enable,
  output logic [7:0] status_byte_two
);

  // ---- synchronisers: chip select and write protect into mclk, busy into sck
  logic [1:0] cs_sync_q;
  logic [1:0] wp_sync_q;
  logic [1:0] bsy_lnk_q;

  // ---- mclk domain state
  logic wel_q;
  logic lock_q;
  logic reset_cmd_enable_q;
  logic busy_q;
  logic soft_reset_q;
  logic gp_q;
  logic gu_q;
  logic cs_prev_q;
  logic fell_q;

  // status levels change only between frames, so the shift-out may
  // read them across domains without a synchroniser
  wire [7:0] stat1_lnk = {lock_q, 5'h00, wel_q, bsy_lnk_q[1]};
  wire [7:0] stat2_lnk = {3'h0, reset_cmd_enable_q, 3'h0, bsy_lnk_q[1]};

  // ---- sck domain
  link_state_t st_q;
  link_state_t st_now;
  link_state_t st_d;
  logic        first_q;
  logic [2:0]  bit_q;
  logic [6:0]  sh_q;
  logic [7:0]  opc_q;
  logic [7:0]  data_q;
  logic        done_q;
  logic [7:0]  tx_q;

  // a deselect restarts the frame at the next sck edge; the frame
  // registers keep their values so mclk can read them after cs rises
  wire [2:0] bit_now  = first_q ? 3'd0 : bit_q;
  wire [6:0] sh_now   = first_q ? 7'h00 : sh_q;
  wire [7:0] rx_byte  = {sh_now, si};
  wire       byte_end = (bit_now == 3'd7);
  assign st_now = first_q ? ST_OPCODE : st_q;

  always_comb begin
    st_d = st_now;
    if (byte_end) begin
      case (st_now)
        ST_OPCODE: begin
          case (rx_byte)
            `OP_WRITE_STATUS:  st_d = ST_WSR_DATA;
            `OP_WRITE_STATUS2: st_d = ST_WS2_DATA;
            `OP_ACTIVE_STATUS: st_d = ST_ACTIVE;
            `OP_READ_STATUS,
            `OP_READ_STATUS2:  st_d = ST_RD_STAT;
            default:           st_d = ST_IGNORE;
          endcase
        end
        ST_WSR_DATA, ST_WS2_DATA: st_d = ST_IGNORE;
        default:                  st_d = st_now;
      endcase
    end
  end

  wire opc_take  = byte_end & (st_now == ST_OPCODE);
  wire data_take = byte_end & ((st_now == ST_WSR_DATA) |
                               (st_now == ST_WS2_DATA));

  // set while deselected, cleared by the first sck edge of a frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      st_q  <= ST_OPCODE;
      bit_q <= 3'd0;
      sh_q  <= 7'h00;
    end else begin
      st_q  <= st_d;
      bit_q <= bit_now + 3'd1;
      sh_q  <= rx_byte[6:0];
    end
  end

  always_ff @(posedge sck or posedge reset) begin
    if (reset)
      opc_q <= 8'h00;
    else if (opc_take)
      opc_q <= rx_byte;
    else if (first_q)
      opc_q <= 8'h00;
  end

  always_ff @(posedge sck or posedge reset) begin
    if (reset)
      data_q <= 8'h00;
    else if (data_take)
      data_q <= rx_byte;
  end

  // a short data byte never sets this, so the write aborts
  always_ff @(posedge sck or posedge reset) begin
    if (reset)
      done_q <= 1'b0;
    else if (data_take)
      done_q <= 1'b1;
    else if (first_q)
      done_q <= 1'b0;
  end

  // busy crossed into sck via two flops for status shift-out
  always_ff @(posedge sck or posedge reset) begin
    if (reset)
      bsy_lnk_q <= 2'b00;
    else
      bsy_lnk_q <= {bsy_lnk_q[0], busy_in};
  end

  // shift status out on falling sck, mode 0 and 3
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n)
      tx_q <= 8'h00;
    else if (bit_q == 3'd0)
      tx_q <= (opc_q == `OP_READ_STATUS2) ? stat2_lnk : stat1_lnk;
    else
      tx_q <= {tx_q[6:0], 1'b0};
  end

  // chip select and write protect through two flops before use
  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_sync_q <= 2'b11;
      wp_sync_q <= 2'b11;
      cs_prev_q <= 1'b1;
      busy_q    <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], cs_n};
      wp_sync_q <= {wp_sync_q[0], wp_n};
      cs_prev_q <= cs_sync_q[1];
      busy_q    <= busy_in;
    end
  end

  // once busy has been seen low in a selected frame the active status
  // output stays low, so a new operation cannot raise it again
  always_ff @(posedge mclk) begin
    if (reset)
      fell_q <= 1'b0;
    else if (cs_sync_q[1])
      fell_q <= 1'b0;
    else
      fell_q <= fell_q | ~busy_q;
  end

  // frame end seen in mclk; frame registers are quiescent while cs high
  wire frame_end = cs_sync_q[1] & ~cs_prev_q;
  wire wp_on     = ~wp_sync_q[1];
  wire [3:0] gcode = data_q[`GLOBAL_MSB:`GLOBAL_LSB];
  wire is_wsr    = (opc_q == `OP_WRITE_STATUS);
  wire is_ws2    = (opc_q == `OP_WRITE_STATUS2);
  wire is_wren   = (opc_q == `OP_WRITE_ENABLE) & (bit_q == 3'd0);
  wire is_wrdi   = (opc_q == `OP_WRITE_DISABLE) & (bit_q == 3'd0);
  wire wsr_ok    = frame_end & is_wsr & done_q & wel_q;
  wire ws2_ok    = frame_end & is_ws2 & done_q & (bit_q == 3'd0) & wel_q;
  wire lock_new  = data_q[`BIT_LOCK];
  wire lock_deny = wp_on & ~lock_new;
  wire wsr_go    = wsr_ok & ~lock_deny;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wel_q        <= 1'b0;
      lock_q       <= 1'b0;
      reset_cmd_enable_q       <= 1'b0;
      soft_reset_q <= 1'b0;
      gp_q         <= 1'b0;
      gu_q         <= 1'b0;
    end else begin
      soft_reset_q <= reset_req & reset_cmd_enable_q;
      gp_q <= wsr_go & ~lock_q & (gcode == GLOBAL_PROTECT_CODE);
      gu_q <= wsr_go & ~lock_q & (gcode == GLOBAL_UNPROTECT_CODE);
      if (wsr_go)
        lock_q <= lock_new;
      if (ws2_ok)
        reset_cmd_enable_q <= data_q[`BIT_RST_EN];
      // status write frame of any length clears the latch; reset cmd does not
      if (frame_end & (is_wsr | is_ws2))
        wel_q <= 1'b0;
      else if (frame_end & is_wrdi)
        wel_q <= 1'b0;
      else if (frame_end & is_wren)
        wel_q <= 1'b1;
    end
  end

  // serial output: active status drives live busy, falling only
  wire active_mode = ~cs_n & ~first_q & (st_q == ST_ACTIVE);
  wire read_mode   = ~cs_n & ~first_q & (st_q == ST_RD_STAT);
  wire act_level   = busy_in & ~fell_q;
  assign so      = active_mode ? act_level : tx_q[7];
  assign so_oe_n = ~(active_mode | read_mode);

  assign soft_reset         = soft_reset_q;
  assign global_protect     = gp_q;
  assign global_unprotect   = gu_q;
  assign write_enable_latch = wel_q;
  assign protect_regs_lock  = lock_q;
  assign reset_cmd_enable   = reset_cmd_enable_q;
  // reserved bits are constant zero; busy readable at any time
  assign status_byte_two = {3'h0, reset_cmd_enable_q, 3'h0, busy_q};

endmodule

// file: logic/flash_status_map.svh
// constants and rule summary for the flash status handling block
// Summary of operation
// - busy flag shows identically in first and second status byte
// - software reset ignored while reset enable bit is zero, accepted when one
// - reset enable bit changes only by second-byte write or power cycle
// - byte two: bit 4 reset enable writable, bit 0 busy read-only
// - byte two bits 7,6,5,3,2,1 reserved and read as zero
// - busy flag readable at any time, even during program or erase
// - active status interrupt starts with chip select and code 25h
// - serial input ignored after the active status interrupt code
// - live busy flag driven on serial output while chip select asserted
// - output falls one to zero when busy clears, never rises
// - chip select release ends interrupt mode and floats serial output
// - write status is code 01h plus one data byte; extra bytes ignored
// - data bit 7 is new lock, bits 5..2 global code, others ignored
// - at frame end lock bit updates and write enable latch clears
// - global operation chosen from bits 5..2 and prior lock value
// - short write status frame aborts but still clears write enable latch
// - with write protect asserted lock may only be set; clear attempt ignored
// - software reset command leaves write enable latch unchanged
// - code 31h plus one byte writes reset enable from bit 4
// - status writes refused while write enable latch is zero
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH
`define OP_WRITE_STATUS    8'h01
`define OP_WRITE_STATUS2   8'h31
`define OP_ACTIVE_STATUS   8'h25
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS     8'h05
`define OP_READ_STATUS2    8'h35
`define OP_RESET_ENABLE_CK 8'hF0
`define BIT_LOCK           7
`define BIT_RST_EN         4
`define BIT_BUSY           0
`define BIT_WEL            1
`define GLOBAL_MSB         5
`define GLOBAL_LSB         2
`define GLOBAL_PROTECT     4'hF
`define GLOBAL_UNPROTECT   4'h0
`endif

// file: logic/flash_status_pkg.sv
// types for the flash status handling block
package flash_status_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE   = 3'b000,
    ST_WSR_DATA = 3'b001,
    ST_WS2_DATA = 3'b010,
    ST_RD_STAT  = 3'b011,
    ST_ACTIVE   = 3'b100,
    ST_IGNORE   = 3'b101
  } link_state_t;
endpackage

// file: sim/spi_host.sv
// host spi master model, mode 0, driving the flash status block
module spi_host (
  // serial link
  output logic sck,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // mode 0 idles sck low, so no dummy bit after 25h
  task automatic frame(input logic [23:0] tx, input int nbits, input bit hold);
    cs_n = 1'b0;
    for (int i = 23; i > 23 - nbits; i--) begin
      si = tx[i];
      #3 sck = 1'b1;
      #3 sck = 1'b0;
    end
    // released line must not keep the last bit
    si = ~si;
    #3 cs_n = hold ? 1'b0 : 1'b1;
    #400;
  endtask
endmodule

// file: sim/spi_flash_status_control_assertions.sv
// concurrent checks on the flash status block ports
module spi_flash_status_control_assertions (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // pins and status
  input wire logic       cs_n,
  input wire logic       wp_n,
  input wire logic       so_oe_n,
  input wire logic       soft_reset,
  input wire logic       global_protect,
  input wire logic       global_unprotect,
  input wire logic       write_enable_latch,
  input wire logic       protect_regs_lock,
  input wire logic       reset_cmd_enable,
  input wire logic [7:0] status_byte_two
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  reserved_zero_a: assert property ({status_byte_two[7:5],
    status_byte_two[3:1]} == 6'h00) else $error("reserved bit set");
  reset_cmd_enable_mirror_a: assert property ($stable(reset_cmd_enable)[*3] |->
    status_byte_two[4] == reset_cmd_enable) else $error("bit 4 stale");
  sr_gated_a: assert property (soft_reset |-> reset_cmd_enable)
    else $error("reset taken while disabled");
  reset_cmd_enable_hold_a: assert property (soft_reset |=>
    $stable(reset_cmd_enable)) else $error("reset changed enable");
  wel_hold_a: assert property (soft_reset |=>
    $stable(write_enable_latch)) else $error("reset changed latch");
  lock_wel_a: assert property ($changed(protect_regs_lock) |->
    $past(write_enable_latch)) else $error("lock moved without latch");
  reset_cmd_enable_wel_a: assert property ($changed(reset_cmd_enable) |->
    $past(write_enable_latch)) else $error("enable moved without latch");
  wp_lock_a: assert property ($fell(protect_regs_lock) |->
    wp_n && $past(wp_n, 4)) else $error("lock cleared under protect");
  glob_pulse_a: assert property (global_protect || global_unprotect |=>
    !(global_protect || global_unprotect)) else $error("long pulse");
  cs_float_a: assert property (cs_n[*4] |-> so_oe_n)
    else $error("output driven while deselected");
  cover property (global_protect);
  cover property (soft_reset);
  cover property ($fell(protect_regs_lock));
endmodule

// file: sim/testbench.sv
// top-level bench for the flash status block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       wp_n = 1'b1;
  logic       busy_in = 1'b0;
  logic       reset_req = 1'b0;
  logic       sck, cs_n, si, so, so_oe_n, soft_reset;
  logic       global_protect, global_unprotect;
  logic       write_enable_latch, protect_regs_lock, reset_cmd_enable;
  logic [7:0] status_byte_two;
  int         miscompares = 0;
  int         checks = 0;
  int         gp_n = 0;
  int         sr_n = 0;
  always #20 mclk = ~mclk;
  spi_flash_status_control uut (.*);
  spi_host host (.*);
  always @(posedge mclk) begin
    gp_n <= gp_n + global_protect;
    sr_n <= sr_n + soft_reset;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wren();
    host.frame(24'h060000, 8, 1'b0);
  endtask
  task automatic req_reset();
    @(posedge mclk) reset_req <= 1'b1;
    @(posedge mclk) reset_req <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #50000 miscompares++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check(status_byte_two, 8'h00);
    req_reset();
    check(8'(sr_n), 8'h00);
    host.frame(24'h31EF00, 16, 1'b0);
    check(reset_cmd_enable, 1'b0);
    wren();
    host.frame(24'h31FF00, 16, 1'b0);
    check(status_byte_two, 8'h10);
    check(write_enable_latch, 1'b0);
    $display("test reset enable done");
    wren();
    req_reset();
    check(8'(sr_n), 8'h01);
    check(reset_cmd_enable, 1'b1);
    check(write_enable_latch, 1'b1);
    $display("test soft reset done");
    @(posedge mclk) busy_in <= 1'b1;
    repeat (4) @(posedge mclk);
    check(status_byte_two[0], 1'b1);
    host.frame(24'h250000, 8, 1'b1);
    check({so_oe_n, so}, 2'b01);
    @(posedge mclk) busy_in <= 1'b0;
    repeat (4) @(posedge mclk);
    check({so_oe_n, so}, 2'b00);
    @(posedge mclk) busy_in <= 1'b1;
    repeat (4) @(posedge mclk);
    check({so_oe_n, so}, 2'b00);
    @(posedge mclk) busy_in <= 1'b0;
    host.frame(24'h0, 0, 1'b0);
    check(so_oe_n, 1'b1);
    $display("test active status done");
    // latch still set from the soft reset test
    host.frame(24'h01BC00, 24, 1'b0);
    check(protect_regs_lock, 1'b1);
    check(8'(gp_n), 8'h01);
    check(write_enable_latch, 1'b0);
    @(posedge mclk) wp_n <= 1'b0;
    wren();
    host.frame(24'h010000, 16, 1'b0);
    check({protect_regs_lock, write_enable_latch}, 2'b10);
    @(posedge mclk) wp_n <= 1'b1;
    wren();
    host.frame(24'h010000, 12, 1'b0);
    check({protect_regs_lock, write_enable_latch}, 2'b10);
    wren();
    host.frame(24'h013C00, 16, 1'b0);
    check(protect_regs_lock, 1'b0);
    check(8'(gp_n), 8'h01);
    $display("test write status done");
    print_verdict();
  end
endmodule
bind spi_flash_status_control spi_flash_status_control_assertions chk (.*);
